// ==== rtl/i2ctdf_regs.vh ====
// Operation
// R1: Send-done flag bit 2, resets 1, write-0 clears
// R2: Second-byte flag bit 1, resets 0, write-0 clears
// R3: First-byte flag bit 0, resets 0, write-0 clears
// R4: Read-only first receive byte register
// R5: Shared address: read second byte, write transmit
// R6: Own address bits 7..1, reset 64h, match only
// R7: Control bit 4 enables first-byte interrupt
// R8: Interrupt while any enabled flag stays set
`ifndef I2CTDF_REGS_VH
`define I2CTDF_REGS_VH

// Register offsets
`define I2CTDF_ADDR_OWN 8'he9
`define I2CTDF_ADDR_CTRL 8'hea
`define I2CTDF_ADDR_RX1 8'heb
`define I2CTDF_ADDR_RX2TX 8'hec

// Address register layout
`define I2CTDF_OWN_RST 8'h64
`define I2CTDF_OWN_EN_BIT 0

// Control/status register layout
`define I2CTDF_SEND_DONE_BIT 2
`define I2CTDF_RX2_FLAG_BIT 1
`define I2CTDF_RX1_FLAG_BIT 0
`define I2CTDF_SEND_IE_BIT 6
`define I2CTDF_RX2_IE_BIT 5
`define I2CTDF_RX1_IE_BIT 4
`define I2CTDF_FLAGS_RST 3'h4
`define I2CTDF_IE_RST 3'h0

// Bits per bus byte
`define I2CTDF_BYTE_BITS 4'h8

`endif

// ==== rtl/i2ctdf_sync.v ====
`timescale 1ns/1ps
module i2ctdf_sync #(
  parameter WIDTH = 2
) (
  input wire clock,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;

  // Bus lines idle high, so the chain resets high to avoid a false start
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          stage1_ff[i] <= 1'b1;
          stage2_ff[i] <= 1'b1;
        end else begin
          stage1_ff[i] <= async_in[i];
          stage2_ff[i] <= stage1_ff[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2_ff;
endmodule // i2ctdf_sync

// ==== rtl/i2ctdf_top.v ====
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "i2ctdf_regs.vh"
module i2ctdf_top (
  input wire clock,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg irq,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n
);
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_ADDR = 6'b000010;
  localparam [5:0] ST_ACK = 6'b000100;
  localparam [5:0] ST_RX = 6'b001000;
  localparam [5:0] ST_TX = 6'b010000;
  localparam [5:0] ST_TACK = 6'b100000;

  function is_wr;
    input [7:0] off;
    begin
      is_wr = reg_wr && (reg_addr == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling and bus events

  wire [1:0] pins_sync;
  reg scl_d_ff;
  reg sda_d_ff;

  i2ctdf_sync #(.WIDTH(2)) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_sync)
  );

  wire scl_s = pins_sync[1];
  wire sda_s = pins_sync[0];
  wire scl_rise = scl_s && !scl_d_ff;
  wire scl_fall = !scl_s && scl_d_ff;
  wire bus_start = scl_s && scl_d_ff && !sda_s && sda_d_ff;
  wire bus_stop = scl_s && scl_d_ff && sda_s && !sda_d_ff;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] own_ff;
  reg [2:0] ie_ff;
  reg [2:0] flags_ff;
  reg [7:0] first_receive_byte_ff;
  reg [7:0] second_receive_byte_ff;
  reg [7:0] tx_byte_ff;

  reg [5:0] state_ff;
  reg [5:0] nxt_state;
  reg [3:0] bit_cnt_ff;
  reg [3:0] nxt_bit_cnt;
  reg [7:0] shift_ff;
  reg [7:0] nxt_shift;
  reg rw_ff;
  reg nxt_rw;
  reg byte_idx_ff;
  reg nxt_byte_idx;
  reg drive_low_ff;
  reg nxt_drive_low;
  reg acked_ff;
  reg nxt_acked;
  reg set_rx1;
  reg set_rx2;
  reg set_send;

  wire enabled = own_ff[`I2CTDF_OWN_EN_BIT];
  wire addr_match = (shift_ff[7:1] == own_ff[7:1]); // R6
  wire byte_done = (bit_cnt_ff == `I2CTDF_BYTE_BITS);

  ////////////////////////////////////////////////////////////////////////
  // Bus engine

  always @* begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_rw = rw_ff;
    nxt_byte_idx = byte_idx_ff;
    nxt_drive_low = drive_low_ff;
    nxt_acked = acked_ff;
    set_rx1 = 1'b0;
    set_rx2 = 1'b0;
    set_send = 1'b0;
    if (!enabled || bus_stop) begin
      nxt_state = ST_IDLE;
      nxt_drive_low = 1'b0;
    end else if (bus_start) begin
      nxt_state = ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_drive_low = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_drive_low = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise && !byte_done) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (state_ff == ST_ADDR) begin
              if (addr_match) begin // R6
                nxt_rw = shift_ff[0];
                nxt_byte_idx = 1'b0;
                nxt_drive_low = 1'b1;
                nxt_state = ST_ACK;
              end else begin
                nxt_state = ST_IDLE;
              end
            end else begin
              set_rx1 = !byte_idx_ff; // R3
              set_rx2 = byte_idx_ff; // R2
              nxt_byte_idx = 1'b1;
              nxt_drive_low = 1'b1;
              nxt_state = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_bit_cnt = 4'h0;
            if (rw_ff) begin
              nxt_shift = {tx_byte_ff[6:0], 1'b0};
              nxt_drive_low = !tx_byte_ff[7];
              nxt_state = ST_TX;
            end else begin
              nxt_drive_low = 1'b0;
              nxt_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (byte_done) begin
              set_send = 1'b1; // R1
              nxt_drive_low = 1'b0;
              nxt_state = ST_TACK;
            end else begin
              nxt_drive_low = !shift_ff[7];
              nxt_shift = {shift_ff[6:0], 1'b0};
            end
          end
        end
        ST_TACK: begin
          // A not-acknowledge ends the read; the bus is left released
          if (scl_rise) begin
            nxt_acked = !sda_s;
          end else if (scl_fall) begin
            if (acked_ff) begin
              nxt_bit_cnt = 4'h0;
              nxt_shift = {tx_byte_ff[6:0], 1'b0};
              nxt_drive_low = !tx_byte_ff[7];
              nxt_state = ST_TX;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_drive_low = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      byte_idx_ff <= 1'b0;
      drive_low_ff <= 1'b0;
      acked_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      rw_ff <= nxt_rw;
      byte_idx_ff <= nxt_byte_idx;
      drive_low_ff <= nxt_drive_low;
      acked_ff <= nxt_acked;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file

  wire [2:0] set_vec = {set_send, set_rx2, set_rx1};
  wire [2:0] wr_flags = reg_wdata[2:0];
  wire [2:0] wr_ie = reg_wdata[6:4];
  wire wr_ctrl = is_wr(`I2CTDF_ADDR_CTRL);
  // Mask follows the write at once so irq never lags a mask change
  wire [2:0] nxt_ie = wr_ctrl ? wr_ie : ie_ff; // R7
  // Writing 0 clears, writing 1 keeps; a same-cycle hardware set wins
  wire [2:0] nxt_flags = (wr_ctrl ? (flags_ff & wr_flags) : flags_ff)
                         | set_vec; // R1 R2 R3

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      own_ff <= `I2CTDF_OWN_RST; // R6
      ie_ff <= `I2CTDF_IE_RST; // R7
      flags_ff <= `I2CTDF_FLAGS_RST; // R1 R2 R3
      first_receive_byte_ff <= 8'h00;
      second_receive_byte_ff <= 8'h00;
      tx_byte_ff <= 8'h00;
    end else begin
      flags_ff <= nxt_flags;
      if (is_wr(`I2CTDF_ADDR_OWN)) begin
        own_ff <= reg_wdata;
      end
      if (wr_ctrl) begin
        ie_ff <= wr_ie; // R7
      end
      // The data register at the rx1 offset ignores writes
      if (set_rx1) begin
        first_receive_byte_ff <= shift_ff; // R4
      end
      if (set_rx2) begin
        second_receive_byte_ff <= shift_ff; // R5
      end
      if (is_wr(`I2CTDF_ADDR_RX2TX)) begin
        tx_byte_ff <= reg_wdata; // R5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port, interrupt and pins

  reg [7:0] nxt_rdata;

  always @* begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `I2CTDF_ADDR_OWN: nxt_rdata = own_ff;
        `I2CTDF_ADDR_CTRL: nxt_rdata = {1'b0, ie_ff, 1'b0, flags_ff};
        `I2CTDF_ADDR_RX1: nxt_rdata = first_receive_byte_ff; // R4
        `I2CTDF_ADDR_RX2TX: nxt_rdata = second_receive_byte_ff; // R5
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      reg_rdata <= nxt_rdata;
      irq <= |(nxt_flags & nxt_ie); // R8
      sda_out <= 1'b0;
      sda_oe_n <= !nxt_drive_low;
    end
  end
endmodule // i2ctdf_top

// ==== bench/i2ctdf_chk.sv ====
`timescale 1ns/1ps
module i2ctdf_chk (
  input wire clock,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire irq,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  wire rd_ea = reg_rd && reg_addr == 8'hea;
  wire wr_ea = reg_wr && reg_addr == 8'hea;
  wire rd_own = reg_rd && reg_addr == 8'he9;
  wire wr_own = reg_wr && reg_addr == 8'he9;
  wire mapped = reg_addr >= 8'he9 && reg_addr <= 8'hec;
  //////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_unmapped_zero: assert property ($past(reg_rd && !mapped) |->
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_ctrl_spare: assert property ($past(rd_ea) |->
    reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0) else $error("spare bit");
  a_own_readback: assert property ($past(wr_own, 3) &&
    !$past(reg_wr, 2) && $past(rd_own) |-> reg_rdata == $past(reg_wdata, 3))
    else $error("own address readback");
  a_irq_match: assert property ($past(rd_ea) |-> $past(irq) ==
    |(reg_rdata[6:4] & reg_rdata[2:0])) else $error("irq vs flags");
  a_irq_clear: assert property (wr_ea && reg_wdata[2:0] == 3'h0 |=> !irq)
    else $error("irq after flag clear");
  a_irq_masked: assert property (wr_ea && reg_wdata[6:4] == 3'h0 |=> !irq)
    else $error("irq while masked");
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  c_irq: cover property ($rose(irq));
  c_ack: cover property ($fell(sda_oe_n));
  c_flag: cover property ($past(rd_ea) && reg_rdata[0]);
endmodule // i2ctdf_chk

// ==== bench/i2ctdf_master.sv ====
`timescale 1ns/1ps
module i2ctdf_master (
  output reg scl,
  output reg sda_drv,
  input wire sda
);
  // Released data reads as the pull-up level; clock idles high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task bit_out(input logic b);
    #20 sda_drv = b;
    #20 scl = 1'b1;
    #40 scl = 1'b0;
  endtask
  task bit_in(output logic b);
    #20 sda_drv = 1'b1;
    #20 scl = 1'b1;
    #20 b = sda;
    #20 scl = 1'b0;
  endtask
  task start;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask
  task stop;
    #20 sda_drv = 1'b0;
    #20 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask
  task wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = !a;
  endtask
  task rbyte(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(nack);
  endtask
endmodule // i2ctdf_master

// ==== bench/i2c_target_data_flags_test.sv ====
`timescale 1ns/1ps
module i2c_target_data_flags_test;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire irq, sda_out, sda_oe_n, scl, m_sda;
  wire sda = m_sda & (sda_oe_n | sda_out);
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] v;
  logic ack;
  // Row: write flag, address, data, expected read
  logic [31:0] rows [11] = '{32'h00_e9_00_64, 32'h00_ea_00_04,
    32'h01_ea_00_00, 32'h00_ea_00_00, 32'h01_ea_70_00, 32'h00_ea_00_70,
    32'h01_f0_ff_00, 32'h00_f0_00_00, 32'h01_e9_65_00, 32'h00_e9_00_65,
    32'h01_ec_a5_00};
  logic [7:0] mw [5] = '{8'h03, 8'h13, 8'h16, 8'h32, 8'h20};
  logic [7:0] me [5] = '{8'h03, 8'h13, 8'h12, 8'h32, 8'h20};
  logic [4:0] mi = 5'b01010;
  i2ctdf_top dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  i2ctdf_master m (.scl(scl), .sda_drv(m_sda), .sda(sda));
  //////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task summarize;
    $display("tests=%0d errors=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial forever #5 clock = ~clock;
  // A hang anywhere is cut short after 500000 ns, far above the normal run length
  initial begin
    #500000;
    bad_count++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      else rd(rows[i][23:16], rows[i][7:0]);
    end
    m.start;
    m.wbyte(8'h64, ack);
    chk({7'h00, ack}, 8'h01);
    m.wbyte(8'h3c, ack);
    m.wbyte(8'hc3, ack);
    m.wbyte(8'h5a, ack);
    m.stop;
    rd(8'heb, 8'h3c);
    rd(8'hec, 8'h5a);
    rd(8'hea, 8'h73);
    chk({7'h00, irq}, 8'h01);
    wr(8'heb, 8'hff);
    rd(8'heb, 8'h3c);
    // Write 1 keeps a flag and never sets one
    foreach (mw[i]) begin
      wr(8'hea, mw[i]);
      chk({7'h00, irq}, {7'h00, mi[i]});
      rd(8'hea, me[i]);
    end
    wr(8'hea, 8'h40);
    m.start;
    m.wbyte(8'h65, ack);
    chk({7'h00, ack}, 8'h01);
    m.rbyte(1'b0, v);
    chk(v, 8'ha5);
    m.rbyte(1'b1, v);
    chk(v, 8'ha5);
    m.stop;
    rd(8'hea, 8'h44);
    chk({7'h00, irq}, 8'h01);
    m.start;
    m.wbyte(8'h66, ack);
    chk({7'h00, ack}, 8'h00);
    m.stop;
    @(posedge clock);
    reset <= 1'b1;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    chk({5'h00, sda_out, irq, sda_oe_n}, 8'h01);
    rd(8'he9, 8'h64);
    rd(8'hea, 8'h04);
    m.start;
    m.wbyte(8'h64, ack);
    chk({7'h00, ack}, 8'h00);
    m.stop;
    summarize;
  end
endmodule // i2c_target_data_flags_test
bind i2ctdf_top i2ctdf_chk chk_u (.clock(clock), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
